// file: src/ebt_bus_sequencer.sv
`timescale 1ns/1ns
module ebt_bus_sequencer
  import ebt_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Wishbone register slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // CPU request and answer
  input  wire logic                  reqValid,
  input  ebt_req_t                   reqIn,
  output logic                       reqReady,
  output logic                       rspValid,
  output logic [EBT_DATA_W-1:0]      rspData,
  // External bus pins
  output logic                       latchOut,
  output logic                       code_read_strobe_n,
  output logic                       dataReadStrobe_n,
  output logic                       write_strobe_low_n,
  output logic                       write_strobe_high_n,
  output logic [EBT_ADDR_W-1:0]      addrOut,
  output logic [EBT_DATA_W-1:0]      dataOut,
  output logic                       dataOe,
  input  wire logic [EBT_DATA_W-1:0] dataIn,
  input  wire logic                  waitIn
);

  ebt_cfg_t              cfg;
  ebt_state_t            state_reg;
  ebt_state_t            state_next;
  logic [4:0]            pos_reg;
  logic [4:0]            pos_next;
  ebt_timing_t           tim_reg;
  ebt_timing_t           tim_next;
  ebt_req_t              req_reg;
  ebt_req_t              req_next;
  ebt_kind_t             lastKind_reg;
  ebt_kind_t             lastKind_next;
  logic                  stall;
  logic                  take;
  logic                  lastPos;
  logic                  inStrobe;
  logic                  sampleOk;
  logic                  bridge;
  logic                  run;
  logic                  strbNext;
  logic                  ready_reg;
  logic                  ready_next;
  logic                  rsp_reg;
  logic                  rsp_next;
  logic [EBT_DATA_W-1:0] rdata_reg;
  logic [EBT_DATA_W-1:0] rdata_next;
  logic                  ale_reg;
  logic                  ale_next;
  logic                  code_reg;
  logic                  code_next;
  logic                  rd_reg;
  logic                  rd_next;
  logic                  wrl_reg;
  logic                  wrl_next;
  logic                  wrh_reg;
  logic                  wrh_next;
  logic [EBT_ADDR_W-1:0] addr_reg;
  logic [EBT_ADDR_W-1:0] addr_next;
  logic [EBT_DATA_W-1:0] dout_reg;
  logic [EBT_DATA_W-1:0] dout_next;
  logic                  oe_reg;
  logic                  oe_next;

  ////////////////////////////////////////////////////////////////////////////
  // Register slave and wait stretcher
  ebt_wb_regs u_regs (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .busy     (state_reg == ST_RUN),
    .lastKind (lastKind_reg),
    .cfg      (cfg)
  );

  ebt_wait_stall u_stall (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .sampleOk (sampleOk),
    .waitIn   (waitIn),
    .stall    (stall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle shape in half clocks, frozen at the start of each cycle
  function automatic ebt_timing_t calcTiming(input ebt_req_t r, input ebt_cfg_t c);
    ebt_timing_t t;
    logic [4:0]  ale;
    logic [4:0]  wr;
    logic [4:0]  hold;
    logic [4:0]  setup;
    ale  = c.latchWidth ? ALE_LONG : ALE_SHORT;
    wr   = c.strobeWidth ? WR_LONG : WR_SHORT;
    hold = c.writeHold ? HOLD_ON : 5'h00;
    t    = '0;
    t.aleEnd = r.latched ? ale : 5'h00;
    case (r.kind)
      KIND_CODE: begin
        if (r.latched) begin
          t.total     = {2'h0, c.latCodeLen + 2'h0, 1'b0} + 5'h04;
          t.strbStart = ale + ALE_GAP;
        end else begin
          t.total     = {2'h0, c.codeLen, 1'b0} + 5'h02;
          t.strbStart = 5'h00;
        end
        t.strbEnd = t.total;
      end
      KIND_READ: begin
        if (r.latched) begin
          t.total     = {2'h0, c.latReadLen, 1'b0} + 5'h04;
          t.strbStart = ale + ALE_GAP;
        end else begin
          t.total     = {2'h0, c.readLen, 1'b0} + 5'h02;
          t.strbStart = 5'h00;
        end
        t.strbEnd = t.total;
      end
      default: begin
        // Same length table for both write forms, setup is what is left
        t.total     = {2'h0, r.latched ? c.latWriteLen : c.writeLen, 1'b0}
                      + 5'h04;
        setup       = t.total - wr - hold;
        // Data leads the strobe by setup less the latch phase
        t.dataStart = r.latched ? ale + ALE_GAP : 5'h00;
        // Invalid settings are clamped so the strobe never precedes data
        t.strbStart = (setup > t.dataStart) ? setup : t.dataStart;
        t.strbEnd   = t.strbStart + wr;
        t.dataEnd   = t.strbEnd + hold;
      end
    endcase
    return t;
  endfunction : calcTiming

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    inStrobe = (state_reg == ST_RUN) && (pos_reg >= tim_reg.strbStart)
               && (pos_reg < tim_reg.strbEnd);
    // Reads may only be held while a full clock of strobe remains
    sampleOk = inStrobe && !(pos_reg[0] ^ tim_reg.strbStart[0])
               && ((req_reg.kind != KIND_READ)
                   || ((pos_reg + READ_WAIT_TAIL) < tim_reg.strbEnd));
    take     = reqValid && ready_reg && (state_reg == ST_IDLE);
    lastPos  = (state_reg == ST_RUN) && !stall && (pos_reg == tim_reg.total - 5'h01);
    state_next    = state_reg;
    pos_next      = pos_reg;
    tim_next      = tim_reg;
    req_next      = req_reg;
    lastKind_next = lastKind_reg;
    rsp_next      = lastPos;
    rdata_next    = rdata_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_RUN;
          pos_next   = 5'h00;
          req_next   = reqIn;
          tim_next   = calcTiming(reqIn, cfg);
        end
      end
      ST_RUN: begin
        if (!stall) begin
          // Read data is taken in the last half clock of the strobe
          if ((req_reg.kind != KIND_WRITE) && (pos_reg == tim_reg.strbEnd - 5'h01)) begin
            rdata_next = dataIn;
          end
          if (lastPos) begin
            state_next    = ST_IDLE;
            lastKind_next = req_reg.kind;
          end else begin
            pos_next = pos_reg + 5'h01;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    ready_next = (state_next == ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, decoded from the coming position so every pin is a flop
  always_comb begin
    run      = (state_next == ST_RUN);
    strbNext = run && (pos_next >= tim_next.strbStart) && (pos_next < tim_next.strbEnd);
    // Unlatched burst fetches leave the code strobe low across the idle half clock
    bridge   = lastPos && (req_reg.kind == KIND_CODE) && req_reg.burst && !req_reg.latched
               && reqValid && reqIn.burst && (reqIn.kind == KIND_CODE)
               && !reqIn.latched;
    ale_next  = run && req_next.latched && (pos_next < tim_next.aleEnd);
    code_next = !((strbNext && (req_next.kind == KIND_CODE)) || bridge);
    rd_next   = !(strbNext && (req_next.kind == KIND_READ));
    wrl_next  = !(strbNext && (req_next.kind == KIND_WRITE) && req_next.byteEn[0]);
    wrh_next  = !(strbNext && (req_next.kind == KIND_WRITE) && req_next.byteEn[1]);
    oe_next   = run && (req_next.kind == KIND_WRITE) && (pos_next >= tim_next.dataStart)
                && (pos_next < tim_next.dataEnd);
    addr_next = run ? req_next.addr : addr_reg;
    dout_next = run ? req_next.wdata : dout_reg;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      pos_reg      <= 5'h00;
      tim_reg      <= '0;
      req_reg      <= '0;
      lastKind_reg <= KIND_CODE;
      ready_reg    <= 1'b0;
      rsp_reg      <= 1'b0;
      rdata_reg    <= '0;
      ale_reg      <= 1'b0;
      code_reg     <= 1'b1;
      rd_reg       <= 1'b1;
      wrl_reg      <= 1'b1;
      wrh_reg      <= 1'b1;
      addr_reg     <= '0;
      dout_reg     <= '0;
      oe_reg       <= 1'b0;
    end else begin
      state_reg    <= state_next;
      pos_reg      <= pos_next;
      tim_reg      <= tim_next;
      req_reg      <= req_next;
      lastKind_reg <= lastKind_next;
      ready_reg    <= ready_next;
      rsp_reg      <= rsp_next;
      rdata_reg    <= rdata_next;
      ale_reg      <= ale_next;
      code_reg     <= code_next;
      rd_reg       <= rd_next;
      wrl_reg      <= wrl_next;
      wrh_reg      <= wrh_next;
      addr_reg     <= addr_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
    end
  end

  assign reqReady            = ready_reg;
  assign rspValid            = rsp_reg;
  assign rspData             = rdata_reg;
  assign latchOut            = ale_reg;
  assign code_read_strobe_n  = code_reg;
  assign dataReadStrobe_n    = rd_reg;
  assign write_strobe_low_n  = wrl_reg;
  assign write_strobe_high_n = wrh_reg;
  assign addrOut             = addr_reg;
  assign dataOut             = dout_reg;
  assign dataOe              = oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic       wrAny_n;
  logic [4:0] strbCnt;
  logic       stallSeen;
  logic [4:0] expWidth;

  assign wrAny_n  = wrl_reg && wrh_reg;
  assign expWidth = tim_reg.strbEnd - tim_reg.strbStart;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strbCnt   <= 5'h00;
      stallSeen <= 1'b0;
    end else begin
      strbCnt   <= wrAny_n ? 5'h00 : strbCnt + 5'h01;
      stallSeen <= wrAny_n ? 1'b0 : (stallSeen || stall);
    end
  end

  sequence s_gapThenStrobe(logic strbN);
    strbN ##1 !strbN;
  endsequence

  sequence s_holdThenFloat;
    dataOe[*2] ##1 !dataOe;
  endsequence

  a_latch_short: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(ale_reg) && (tim_reg.aleEnd == 5'h01) |=> !ale_reg)
    else $error("latch pulse not half a clock");

  a_latch_long: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(ale_reg) && (tim_reg.aleEnd == 5'h03) |-> ale_reg[*3] ##1 !ale_reg)
    else $error("latch pulse not one and a half clocks");

  a_code_gap: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(ale_reg) && (req_reg.kind == KIND_CODE) |-> s_gapThenStrobe(code_reg))
    else $error("code strobe not half a clock after latch");

  a_read_gap: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(ale_reg) && (req_reg.kind == KIND_READ) |-> s_gapThenStrobe(rd_reg))
    else $error("read strobe not half a clock after latch");

  a_write_width: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(wrAny_n) && !stallSeen |-> strbCnt == expWidth)
    else $error("write strobe width wrong");

  a_write_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(wrAny_n) |-> s_holdThenFloat)
    else $error("write data not held one clock");

  a_data_lead: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(wrAny_n) |-> dataOe && ((tim_reg.strbStart == tim_reg.dataStart) || $past(dataOe)))
    else $error("write data not ahead of strobe");

  a_wait_window: assert property (@(posedge mclk) disable iff (!rst_n)
    stall |-> inStrobe && ((req_reg.kind != KIND_READ)
                           || (pos_reg + READ_WAIT_TAIL < tim_reg.strbEnd)))
    else $error("wait honoured outside its window");

  a_wait_clock: assert property (@(posedge mclk) disable iff (!rst_n)
    sampleOk && waitIn && !$past(stall)
    |=> (pos_reg == $past(pos_reg)) ##1 (pos_reg == $past(pos_reg, 2)))
    else $error("asserted wait sample did not hold the strobe a clock");

endmodule : ebt_bus_sequencer

// file: src/ebt_pkg.sv
package ebt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [3:0] OFS_TIMING_LOW  = 4'h0;
  localparam logic [3:0] OFS_TIMING_HIGH = 4'h4;
  localparam logic [3:0] OFS_STATUS      = 4'h8;

  // Fields of bus_timing_low_reg
  localparam int POS_CODE_LEN     = 0;
  localparam int POS_LAT_CODE_LEN = 2;
  localparam int POS_LATCH_WIDTH  = 4;
  localparam int POS_WRITE_HOLD   = 5;
  localparam int POS_STROBE_WIDTH = 6;
  // Fields of bus_timing_high_reg
  localparam int POS_READ_LEN      = 0;
  localparam int POS_LAT_READ_LEN  = 2;
  localparam int POS_WRITE_LEN     = 4;
  localparam int POS_LAT_WRITE_LEN = 6;
  // Fields of the status register
  localparam int POS_BUSY      = 0;
  localparam int POS_LAST_KIND = 1;

  localparam logic [7:0] RST_TIMING_LOW  = 8'h6F;
  localparam logic [7:0] RST_TIMING_HIGH = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, counted in half CPU clocks; one half clock is one mclk cycle
  localparam int          HALVES_PER_CLK = 2;
  localparam logic [4:0]  ALE_SHORT      = 5'h01;
  localparam logic [4:0]  ALE_LONG       = 5'h03;
  localparam logic [4:0]  ALE_GAP        = 5'h01;
  localparam logic [4:0]  WR_SHORT       = 5'h02;
  localparam logic [4:0]  WR_LONG        = 5'h04;
  localparam logic [4:0]  HOLD_ON        = 5'h02;
  localparam logic [4:0]  READ_WAIT_TAIL = 5'h02;

  localparam int EBT_ADDR_W = 24;
  localparam int EBT_DATA_W = 16;

  typedef enum logic [1:0] {
    KIND_CODE  = 2'b00,
    KIND_READ  = 2'b01,
    KIND_WRITE = 2'b10
  } ebt_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } ebt_state_t;

  typedef struct packed {
    ebt_kind_t               kind;
    logic                    latched;
    logic                    burst;
    logic [EBT_ADDR_W-1:0]   addr;
    logic [EBT_DATA_W-1:0]   wdata;
    logic [1:0]              byteEn;
  } ebt_req_t;

  typedef struct packed {
    logic [1:0] codeLen;
    logic [1:0] latCodeLen;
    logic       latchWidth;
    logic       writeHold;
    logic       strobeWidth;
    logic [1:0] readLen;
    logic [1:0] latReadLen;
    logic [1:0] writeLen;
    logic [1:0] latWriteLen;
  } ebt_cfg_t;

  typedef struct packed {
    logic [4:0] aleEnd;
    logic [4:0] strbStart;
    logic [4:0] strbEnd;
    logic [4:0] dataStart;
    logic [4:0] dataEnd;
    logic [4:0] total;
  } ebt_timing_t;

endpackage : ebt_pkg

// file: src/ebt_wait_stall.sv
`timescale 1ns/1ns
module ebt_wait_stall
  import ebt_pkg::*;
#(
  parameter logic [1:0] STALL_EXTRA = 2'h1
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Strobe state
  input  wire logic sampleOk,
  input  wire logic waitIn,
  // Freeze request
  output logic      stall
);

  logic [1:0] cntReg;
  logic [1:0] cntNext;
  logic       hit;

  ////////////////////////////////////////////////////////////////////////////
  // One sample per clock; a hit freezes the sequencer for one whole clock
  always_comb begin
    hit     = sampleOk && (cntReg == 2'h0) && waitIn;
    cntNext = cntReg;
    if (hit) begin
      cntNext = STALL_EXTRA;
    end else if (cntReg != 2'h0) begin
      cntNext = cntReg - 2'h1;
    end
    stall = hit || (cntReg != 2'h0);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cntReg <= 2'h0;
    end else begin
      cntReg <= cntNext;
    end
  end

endmodule : ebt_wait_stall

// file: src/ebt_wb_regs.sv
`timescale 1ns/1ns
module ebt_wb_regs
  import ebt_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Block side
  input  wire logic        busy,
  input  ebt_kind_t        lastKind,
  output ebt_cfg_t         cfg
);

  logic [7:0]  lowReg;
  logic [7:0]  lowNext;
  logic [7:0]  highReg;
  logic [7:0]  highNext;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        hit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    hit      = wb_cyc_i && wb_stb_i && !ack_reg;
    ack_next = hit;
    lowNext  = lowReg;
    highNext = highReg;
    dat_next = 32'h0000_0000;
    // Writes land on the acknowledged edge, while the master still holds its data
    if (ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == OFS_TIMING_LOW) begin
        lowNext = wb_dat_i[7:0];
      end
      if (wb_adr_i == OFS_TIMING_HIGH) begin
        highNext = wb_dat_i[7:0];
      end
    end
    // Writes must always use the extended hold, so this bit is stuck at one
    lowNext[POS_WRITE_HOLD] = 1'b1;
    if (hit && !wb_we_i) begin
      case (wb_adr_i)
        OFS_TIMING_LOW:  dat_next[7:0] = lowReg;
        OFS_TIMING_HIGH: dat_next[7:0] = highReg;
        OFS_STATUS: begin
          dat_next[POS_BUSY]                   = busy;
          dat_next[POS_LAST_KIND+1:POS_LAST_KIND] = lastKind;
        end
        default:         dat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lowReg  <= RST_TIMING_LOW;
      highReg <= RST_TIMING_HIGH;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      lowReg  <= lowNext;
      highReg <= highNext;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o         = ack_reg;
  assign wb_dat_o         = dat_reg;
  assign cfg.codeLen      = lowReg[POS_CODE_LEN+1:POS_CODE_LEN];
  assign cfg.latCodeLen   = lowReg[POS_LAT_CODE_LEN+1:POS_LAT_CODE_LEN];
  assign cfg.latchWidth   = lowReg[POS_LATCH_WIDTH];
  assign cfg.writeHold    = lowReg[POS_WRITE_HOLD];
  assign cfg.strobeWidth  = lowReg[POS_STROBE_WIDTH];
  assign cfg.readLen      = highReg[POS_READ_LEN+1:POS_READ_LEN];
  assign cfg.latReadLen   = highReg[POS_LAT_READ_LEN+1:POS_LAT_READ_LEN];
  assign cfg.writeLen     = highReg[POS_WRITE_LEN+1:POS_WRITE_LEN];
  assign cfg.latWriteLen  = highReg[POS_LAT_WRITE_LEN+1:POS_LAT_WRITE_LEN];

endmodule : ebt_wb_regs

// file: test/ebt_ext_mem.sv
`timescale 1ns/1ns
module ebt_ext_mem
  import ebt_pkg::*;
(
  // Bus pins
  input  wire logic                  mclk,
  input  wire logic                  codeN,
  input  wire logic                  readN,
  input  wire logic                  wrLowN,
  input  wire logic                  wrHighN,
  input  wire logic [EBT_ADDR_W-1:0] addrOut,
  // Bench control
  input  wire logic                  waitOn,
  // Answers
  output logic [EBT_DATA_W-1:0]      dataIn,
  output logic                       waitIn
);
  logic                  strbLow;
  logic [3:0]            lowCnt = 4'h0;
  logic [2:0]            prevLowAddr = 3'h0;
  logic                  newCycle;
  logic [EBT_DATA_W-1:0] pat;
  assign strbLow = !codeN || !readN || !wrLowN || !wrHighN;
  assign pat     = addrOut[15:0] ^ 16'hA5C3;
  // Undriven bus shows inverted data, so a late capture cannot match
  assign dataIn  = (!codeN || !readN) ? pat : ~pat;
  // Wait only in the first CPU clock of a strobe: at most one hit, none for a one-clock read
  // A burst keeps the code strobe low, so a new cycle shows on the low address lines
  assign newCycle = addrOut[3:1] != prevLowAddr;
  assign waitIn  = waitOn && strbLow && (newCycle || lowCnt < 4'h2);
  always_ff @(posedge mclk) begin
    prevLowAddr <= addrOut[3:1];
    lowCnt      <= !strbLow ? 4'h0 : newCycle ? 4'h1 : lowCnt + 4'h1;
  end
endmodule : ebt_ext_mem

// file: test/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import ebt_pkg::*;
;
  logic mclk, rst_n, wbCyc, wbStb, wbWe, wbAck, reqValid, reqReady, rspValid, latchOut;
  logic codeN, readN, wrLN, wrHN, dataOe, waitIn, waitOn, act, done;
  logic [3:0] wbAdr;
  logic [31:0] wbDat, wbDatO, q;
  ebt_req_t r;
  logic [15:0] rspData, dataOut, dataIn;
  logic [23:0] addrOut;
  logic [1:0] cl, lcl, rl, lrl, wl, lwl;
  logic aw, sw;
  int cyc, sC, lC, oC, hC, fS, wlC, whC, err_count, comparisons;

  ebt_bus_sequencer DUT (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .reqValid(reqValid), .reqIn(r), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .latchOut(latchOut), .code_read_strobe_n(codeN),
    .dataReadStrobe_n(readN), .write_strobe_low_n(wrLN), .write_strobe_high_n(wrHN),
    .addrOut(addrOut), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn), .waitIn(waitIn));
  ebt_ext_mem mem (.mclk(mclk), .codeN(codeN), .readN(readN), .wrLowN(wrLN), .wrHighN(wrHN),
    .addrOut(addrOut), .waitOn(waitOn), .dataIn(dataIn), .waitIn(waitIn));

  ////////////////////////////////////////
  // Cycle monitor: counts per cycle index after the take
  always @(posedge mclk) begin
    if (reqValid && reqReady) begin
      {act, done, cyc, sC, lC, oC, hC, fS, wlC, whC} <= {2'b10, 32'd1, 224'd0};
    end else if (act) begin
      lC  <= lC + latchOut;
      oC  <= oC + dataOe;
      wlC <= wlC + !wrLN;
      whC <= whC + !wrHN;
      if (!codeN || !readN || !wrLN || !wrHN) begin
        sC <= sC + 1;
        if (fS == 0) fS <= cyc;
      end else if (dataOe && sC > 0) hC <= hC + 1;
      if (rspValid) begin
        act  <= 1'b0;
        done <= 1'b1;
      end else begin
        cyc <= cyc + 1;
      end
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDat} <= {2'b11, we, a, d};
    do @(posedge mclk); while (wbAck !== 1'b1 && ++n < 50);
    if (n >= 50) err_count++;
    q = wbDatO;
    {wbCyc, wbStb} <= 2'b00;
  endtask : wb

  function automatic int halves(ebt_kind_t k, logic l);
    logic [1:0] f;
    f = (k == KIND_CODE) ? (l ? lcl : cl) : (k == KIND_READ) ? (l ? lrl : rl) : (l ? lwl : wl);
    return (k != KIND_WRITE && !l) ? 2 * (f + 1) : 2 * (f + 2);
  endfunction : halves

  function automatic bit legal(ebt_req_t x);
    int h;
    h = halves(x.kind, x.latched);
    if (x.kind == KIND_WRITE) return h - (sw ? 4 : 2) - 2 - (x.latched ? (aw ? 4 : 2) : 0) >= 0;
    return !x.latched || h - (aw ? 3 : 1) - 1 >= 2;
  endfunction : legal

  task automatic set_cfg;
    wb(1'b1, OFS_TIMING_LOW, {24'h0, 1'b0, sw, 1'b1, aw, lcl, cl});
    wb(1'b1, OFS_TIMING_HIGH, {24'h0, lwl, wl, lrl, rl});
  endtask : set_cfg

  task automatic xfer(input logic wt);
    int h, s, st, lh, n;
    h  = halves(r.kind, r.latched);
    lh = aw ? 3 : 1;
    s  = (r.kind == KIND_WRITE) ? (sw ? 4 : 2) : (r.latched ? h - lh - 1 : h);
    // A one-clock data read cannot be stretched
    st = (wt && (r.kind != KIND_READ || s > 2)) ? 2 : 0;
    n  = 0;
    @(posedge mclk);
    {waitOn, reqValid} <= {wt, 1'b1};
    do @(posedge mclk); while (reqReady !== 1'b1 && ++n < 100);
    reqValid <= 1'b0;
    do @(negedge mclk); while (done !== 1'b1 && ++n < 300);
    if (n >= 300) err_count++;
    waitOn <= 1'b0;
    chk("latency", cyc, 1 + h + st);
    chk("latch", lC, r.latched ? lh : 0);
    chk("strobe", sC, s + st);
    if (r.kind == KIND_WRITE) begin
      chk("wrLow", wlC, r.byteEn[0] ? s + st : 0);
      chk("wrHigh", whC, r.byteEn[1] ? s + st : 0);
      chk("wrStart", fS, 1 + h - s - 2);
      chk("dataOe", oC, (r.latched ? h - lh - 1 : h) + st);
      chk("hold", hC, 2);
      chk("wrData", dataOut, r.wdata);
    end else begin
      chk("rdStart", fS, r.latched ? lh + 2 : 1);
      chk("rdData", rspData, r.addr[15:0] ^ 16'hA5C3);
    end
    chk("addr", addrOut, r.addr);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("status", q, {29'h0, r.kind, 1'b0});
  endtask : xfer

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    final_report();
  end

  ////////////////////////////////////////
  initial begin
    {rst_n, wbCyc, wbStb, wbWe, wbAdr, wbDat, reqValid, waitOn, act, done} = '0;
    r = '0;
    void'($urandom(38));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    wb(1'b0, OFS_TIMING_LOW, 32'h0);
    chk("rstLow", q, {24'h0, RST_TIMING_LOW});
    wb(1'b0, OFS_TIMING_HIGH, 32'h0);
    chk("rstHigh", q, {24'h0, RST_TIMING_HIGH});
    wb(1'b1, OFS_TIMING_LOW, 32'h00);
    wb(1'b0, OFS_TIMING_LOW, 32'h0);
    chk("holdBit", q, 32'h20);
    wb(1'b0, 4'hC, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test registers done");
    {cl, lcl, rl, lrl, wl, lwl, aw, sw} = {2'h1, 2'h3, 2'h0, 2'h3, 2'h3, 2'h3, 2'b00};
    set_cfg();
    r = '{KIND_CODE, 1'b0, 1'b0, 24'h00123A, 16'h0, 2'h3};
    xfer(1'b1);
    r.kind = KIND_READ;
    xfer(1'b1);
    r = '{KIND_WRITE, 1'b0, 1'b0, 24'h000456, 16'h5AA5, 2'h2};
    xfer(1'b1);
    $display("test wait done");
    repeat (60) begin
      do begin
        {cl, lcl, rl, lrl, wl, lwl, aw, sw} = 14'($urandom);
        r = '{ebt_kind_t'($urandom_range(0, 2)), 1'($urandom), 1'b0, 24'($urandom),
              16'($urandom), 2'($urandom_range(1, 3))};
      end while (!legal(r));
      set_cfg();
      xfer(1'b0);
    end
    $display("test random done");
    final_report();
  end
endmodule : tb_top
